// File: logic/sbp_pkg.sv
// Shared constants for the burst-of-four byte-masked memory port.
// Assumes one core clock; each core cycle stands for one half of the port clock.
package sbp_pkg;

    // Data lane and default widths
    localparam int LANE_W       = 9;
    localparam int DEF_ADDR_W   = 10;
    localparam int DEF_DATA_W   = 36;

    // Burst shape
    localparam int       OFF_W      = 2;
    localparam int       BURST_LEN  = 4;
    localparam bit [1:0] LAST_OFF   = 2'h3;
    localparam bit [1:0] OFF_FIRST  = 2'h0;

    // Device side timing, in core cycles after the command cycle
    localparam bit [1:0] RD_PEND_LAST  = 2'h1;

    // Controller side timing: write steps in core cycles after the command cycle, read end as a beat count
    localparam int       WR_FIRST_BEAT = 2;
    localparam bit [2:0] WR_LOAD_FIRST = 3'(WR_FIRST_BEAT - 1);
    localparam bit [2:0] WR_LAST       = 3'(WR_FIRST_BEAT + BURST_LEN - 1);
    localparam bit [1:0] RD_BEAT_LAST  = 2'(BURST_LEN - 1);

endpackage

// File: logic/sbp_if.sv
// Port between the memory device end and the controller end.
// Assumes both ends run on the same core clock; no tristate on this port.
`timescale 1ns/1ps
interface sbp_if #(
    parameter int ADDR_W = sbp_pkg::DEF_ADDR_W,
    parameter int DATA_W = sbp_pkg::DEF_DATA_W
);
    localparam int LANES = DATA_W / sbp_pkg::LANE_W;

    logic              k_phase;
    logic              rd_sel_n;
    logic              wr_sel_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0]  lane_write_strobe_n;
    logic [DATA_W-1:0] q;
    logic              q_valid;

    modport mem (
        input  k_phase,
        input  rd_sel_n,
        input  wr_sel_n,
        input  addr,
        input  d,
        input  lane_write_strobe_n,
        output q,
        output q_valid
    );

    modport ctl (
        output k_phase,
        output rd_sel_n,
        output wr_sel_n,
        output addr,
        output d,
        output lane_write_strobe_n,
        input  q,
        input  q_valid
    );
endinterface // sbp_if

// File: logic/sbp_mem_dev.sv
// Memory device end: burst-of-four storage with per-lane write masks.
// Assumes the controller drives k_phase high in true-edge cycles, low otherwise.
//
// Summary of operation
// - Nine-bit width: one strobe gates all bits
// - Eighteen-bit width: two strobes gate nine-bit lanes
// - Thirty-six-bit width: four strobes gate nine-bit lanes
// - Strobes apply per beat, sampled each beat
// - Two internal offset bits extend the address
// - Offset counts 0,1,2,3 then burst ends
// - Read and write engines run independently
// - Simultaneous read and write: read wins
// - Commands sampled on true edges only
// - Write beats follow one and two true edges later
// - Data captured and launched every half cycle
// - Same command on consecutive true edges ignored
`timescale 1ns/1ps
module sbp_mem_dev #(
    parameter int ADDR_W = sbp_pkg::DEF_ADDR_W,
    parameter int DATA_W = sbp_pkg::DEF_DATA_W
) (
    // Clock and reset
    input  wire logic CORE_CLK,
    input  wire logic NRST,
    // Memory port
    sbp_if.mem        PORT,
    // Status
    output logic      RD_ACTIVE,
    output logic      WR_ACTIVE
);
    localparam int LANES = DATA_W / sbp_pkg::LANE_W;
    localparam int WA_W  = ADDR_W + sbp_pkg::OFF_W;
    localparam int DEPTH = 1 << WA_W;

    typedef enum logic [1:0] {
        RD_IDLE  = 2'b01,
        RD_BURST = 2'b10
    } sbp_rd_e;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_DATA = 2'b10
    } sbp_wr_e;

    typedef struct packed {
        logic              rd_prev;
        logic              wr_prev;
        logic              rd_pv;
        logic [1:0]        rd_wait;
        logic [ADDR_W-1:0] rd_pa;
        sbp_rd_e           rd_st;
        logic [1:0]        rd_off;
        logic [ADDR_W-1:0] rd_addr;
        logic              wr_pv;
        logic [ADDR_W-1:0] wr_pa;
        sbp_wr_e           wr_st;
        logic [1:0]        wr_off;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] q;
        logic              q_valid;
        logic              rd_act;
        logic              wr_act;
    } sbp_dev_s;

    sbp_dev_s          s_q;
    sbp_dev_s          s_d;
    logic [DATA_W-1:0] mem [DEPTH];
    logic              rd_go;
    logic              wr_go;
    logic              mem_we;
    logic [WA_W-1:0]   mem_wa;
    logic [DATA_W-1:0] mem_mask;

    // Expand active-low lane strobes into a bit mask
    function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] strobe_n);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*sbp_pkg::LANE_W +: sbp_pkg::LANE_W] = {sbp_pkg::LANE_W{~strobe_n[i]}};
        end
        return m;
    endfunction

    always_comb begin
        s_d       = s_q;
        s_d.q_valid = 1'b0;
        rd_go     = 1'b0;
        wr_go     = 1'b0;
        mem_we    = 1'b0;
        mem_wa    = '0;
        mem_mask  = '0;

        // Command sampling on true edges
        if (PORT.k_phase) begin
            rd_go      = !PORT.rd_sel_n && !s_q.rd_prev;
            wr_go      = !PORT.wr_sel_n && PORT.rd_sel_n && !s_q.wr_prev;
            s_d.rd_prev = !PORT.rd_sel_n;
            s_d.wr_prev = !PORT.wr_sel_n;
        end

        // Read burst: one word launched every core cycle
        unique case (s_q.rd_st)
            RD_IDLE: begin
            end
            RD_BURST: begin
                s_d.q       = mem[{s_q.rd_addr, s_q.rd_off}];
                s_d.q_valid = 1'b1;
                s_d.rd_off  = s_q.rd_off + 2'h1;
                if (s_q.rd_off == sbp_pkg::LAST_OFF) begin
                    s_d.rd_st = RD_IDLE;
                end
            end
        endcase

        // Read latency slot, may overlap the tail of the prior burst
        if (s_q.rd_pv) begin
            s_d.rd_wait = s_q.rd_wait + 2'h1;
            if (s_q.rd_wait == sbp_pkg::RD_PEND_LAST) begin
                s_d.rd_pv   = 1'b0;
                s_d.rd_st   = RD_BURST;
                s_d.rd_addr = s_q.rd_pa;
                s_d.rd_off  = sbp_pkg::OFF_FIRST;
            end
        end
        if (rd_go) begin
            s_d.rd_pv   = 1'b1;
            s_d.rd_wait = 2'h0;
            s_d.rd_pa   = PORT.addr;
        end

        // Write burst: strobes of each beat steer that beat only
        unique case (s_q.wr_st)
            WR_IDLE: begin
            end
            WR_DATA: begin
                mem_we     = 1'b1;
                mem_wa     = {s_q.wr_addr, s_q.wr_off};
                mem_mask   = lane_mask(PORT.lane_write_strobe_n);
                s_d.wr_off = s_q.wr_off + 2'h1;
                if (s_q.wr_off == sbp_pkg::LAST_OFF) begin
                    s_d.wr_st = WR_IDLE;
                end
            end
        endcase

        // First write beat comes two cycles after the command
        if (s_q.wr_pv) begin
            s_d.wr_pv   = 1'b0;
            s_d.wr_st   = WR_DATA;
            s_d.wr_addr = s_q.wr_pa;
            s_d.wr_off  = sbp_pkg::OFF_FIRST;
        end
        if (wr_go) begin
            s_d.wr_pv = 1'b1;
            s_d.wr_pa = PORT.addr;
        end

        s_d.rd_act = s_d.rd_pv || (s_d.rd_st == RD_BURST);
        s_d.wr_act = s_d.wr_pv || (s_d.wr_st == WR_DATA);
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            s_q         <= '0;
            s_q.rd_st   <= RD_IDLE;
            s_q.wr_st   <= WR_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage; masked lanes are left as they were
    always_ff @(posedge CORE_CLK) begin
        if (mem_we) begin
            mem[mem_wa] <= (mem[mem_wa] & ~mem_mask) | (PORT.d & mem_mask);
        end
    end

    assign PORT.q       = s_q.q;
    assign PORT.q_valid = s_q.q_valid;
    assign RD_ACTIVE    = s_q.rd_act;
    assign WR_ACTIVE    = s_q.wr_act;

endmodule // sbp_mem_dev

// File: logic/sbp_ctl_host.sv
// Controller end: turns whole-burst requests into port commands and beats.
// Assumes a user that holds a request until it is taken; one burst per engine.
`timescale 1ns/1ps
module sbp_ctl_host #(
    parameter int ADDR_W = sbp_pkg::DEF_ADDR_W,
    parameter int DATA_W = sbp_pkg::DEF_DATA_W
) (
    // Clock and reset
    input  wire logic                    CORE_CLK,
    input  wire logic                    NRST,
    // Memory port
    sbp_if.ctl                           PORT,
    // Request
    input  wire logic                    REQ_VALID,
    input  wire logic                    REQ_WRITE,
    input  wire logic [ADDR_W-1:0]       REQ_ADDR,
    input  wire logic [4*DATA_W-1:0]     REQ_WDATA,
    input  wire logic [4*(DATA_W/9)-1:0] REQ_STROBE_N,
    output logic                         REQ_READY,
    // Read answer
    output logic                         RSP_VALID,
    output logic [4*DATA_W-1:0]          RSP_RDATA
);
    localparam int LANES = DATA_W / sbp_pkg::LANE_W;
    localparam int BW    = sbp_pkg::BURST_LEN * DATA_W;
    localparam int BM    = sbp_pkg::BURST_LEN * LANES;

    typedef struct packed {
        logic              phase;
        logic              ready;
        logic              rd_sel_n;
        logic              wr_sel_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] d;
        logic [LANES-1:0]  strobe_n;
        logic              w_busy;
        logic [2:0]        w_cnt;
        logic [BW-1:0]     w_buf;
        logic [BM-1:0]     w_mask;
        logic              r_busy;
        logic [1:0]        r_cnt;
        logic [BW-1:0]     r_buf;
        logic              rsp_valid;
    } sbp_ctl_s;

    sbp_ctl_s s_q;
    sbp_ctl_s s_d;
    logic     take;

    always_comb begin
        s_d           = s_q;
        s_d.phase     = !s_q.phase;
        s_d.rd_sel_n  = 1'b1;
        s_d.wr_sel_n  = 1'b1;
        s_d.rsp_valid = 1'b0;
        take          = REQ_VALID && s_q.ready;

        // Write beats: word k on the k-th half cycle from the second
        if (s_q.w_busy) begin
            s_d.w_cnt = s_q.w_cnt + 3'h1;
            if (s_q.w_cnt >= sbp_pkg::WR_LOAD_FIRST && s_q.w_cnt < sbp_pkg::WR_LAST) begin
                s_d.d        = s_q.w_buf[DATA_W-1:0];
                s_d.strobe_n = s_q.w_mask[LANES-1:0];
                s_d.w_buf    = {{DATA_W{1'b0}}, s_q.w_buf[BW-1:DATA_W]};
                s_d.w_mask   = {{LANES{1'b1}}, s_q.w_mask[BM-1:LANES]};
            end else begin
                s_d.strobe_n = '1;
            end
            if (s_q.w_cnt == sbp_pkg::WR_LAST) begin
                s_d.w_busy = 1'b0;
            end
        end

        // Read beats collected in arrival order
        if (s_q.r_busy && PORT.q_valid) begin
            s_d.r_buf = {PORT.q, s_q.r_buf[BW-1:DATA_W]};
            s_d.r_cnt = s_q.r_cnt + 2'h1;
            if (s_q.r_cnt == sbp_pkg::RD_BEAT_LAST) begin
                s_d.r_busy    = 1'b0;
                s_d.rsp_valid = 1'b1;
            end
        end

        // One command per true edge; engines idle keeps bursts apart
        if (take) begin
            s_d.addr = REQ_ADDR;
            if (REQ_WRITE) begin
                s_d.wr_sel_n = 1'b0;
                s_d.w_busy   = 1'b1;
                s_d.w_cnt    = 3'h0;
                s_d.w_buf    = REQ_WDATA;
                s_d.w_mask   = REQ_STROBE_N;
            end else begin
                s_d.rd_sel_n = 1'b0;
                s_d.r_busy   = 1'b1;
                s_d.r_cnt    = 2'h0;
            end
        end

        s_d.ready = !s_d.phase && !s_d.w_busy && !s_d.r_busy;
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            s_q          <= '0;
            s_q.rd_sel_n <= 1'b1;
            s_q.wr_sel_n <= 1'b1;
            s_q.strobe_n <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign PORT.k_phase             = s_q.phase;
    assign PORT.rd_sel_n            = s_q.rd_sel_n;
    assign PORT.wr_sel_n            = s_q.wr_sel_n;
    assign PORT.addr                = s_q.addr;
    assign PORT.d                   = s_q.d;
    assign PORT.lane_write_strobe_n = s_q.strobe_n;
    assign REQ_READY                = s_q.ready;
    assign RSP_VALID                = s_q.rsp_valid;
    assign RSP_RDATA                = s_q.r_buf;

endmodule // sbp_ctl_host

// File: dv/sbp_chk_sva.sv
// Port checker between controller end and device end.
// Assumes instantiation beside the interface, one core clock.
`timescale 1ns/1ps
module sbp_chk_sva #(
    parameter int DATA_W = sbp_pkg::DEF_DATA_W
) (
    // Clock and reset
    input wire logic                CORE_CLK,
    input wire logic                NRST,
    // Port
    input wire logic                k_phase,
    input wire logic                rd_sel_n,
    input wire logic                wr_sel_n,
    input wire logic [DATA_W/9-1:0] lane_write_strobe_n,
    input wire logic                q_valid
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    k_toggle_a: assert property ($past(NRST) |-> k_phase != $past(k_phase))
        else $error("k_phase stalled");
    sel_true_a: assert property (!rd_sel_n || !wr_sel_n |-> k_phase)
        else $error("select off true edge");
    one_cmd_a: assert property (rd_sel_n || wr_sel_n)
        else $error("both selects low");
    rd_beats_a: assert property (k_phase && !rd_sel_n |-> ##4 q_valid [*4] ##1 !q_valid)
        else $error("read beats wrong");
    q_cause_a: assert property ($rose(q_valid) |-> k_phase && !$past(rd_sel_n, 4))
        else $error("q_valid without read");
    wr_frame_a: assert property (k_phase && !wr_sel_n |=> (&lane_write_strobe_n) ##5 (&lane_write_strobe_n))
        else $error("strobes outside beats");
    strb_win_a: assert property (!(&lane_write_strobe_n) |-> !$past(wr_sel_n, 2) || !$past(wr_sel_n, 3)
        || !$past(wr_sel_n, 4) || !$past(wr_sel_n, 5))
        else $error("strobe without write");
    rw_gap_a: assert property (k_phase && (!rd_sel_n || !wr_sel_n) |-> ##2 rd_sel_n && wr_sel_n)
        else $error("command two true edges in a row");
endmodule // sbp_chk_sva

// File: dv/tb_sram_burst4_byte_write_port.sv
// Bench: controller end against device end, and a bench-driven 18-bit device.
// Assumes package, interface and both ends compiled first.
`timescale 1ns/1ps
module tb_sram_burst4_byte_write_port;
    logic         clk;
    logic         nrst;
    logic         rv;
    logic         rw;
    logic [9:0]   ra;
    logic [143:0] wd;
    logic [15:0]  rs;
    logic         rdy;
    logic         ok;
    logic [143:0] rq;
    logic [35:0]  ma [4096];
    logic [17:0]  mb [4096];
    logic [143:0] qa [$];
    logic [17:0]  qb [$];
    logic [9:0]   b;
    logic         ra_act;
    logic         wa_act;
    logic         rb_act;
    logic         wb_act;
    int           miscompares;
    int           num_checks;
    sbp_if #(.DATA_W(36)) ifa ();
    sbp_if #(.DATA_W(18)) ifb ();
    sbp_ctl_host #(.DATA_W(36)) sbp_ctl_host_i (.CORE_CLK(clk), .NRST(nrst), .PORT(ifa),
        .REQ_VALID(rv), .REQ_WRITE(rw), .REQ_ADDR(ra), .REQ_WDATA(wd), .REQ_STROBE_N(rs),
        .REQ_READY(rdy), .RSP_VALID(ok), .RSP_RDATA(rq));
    sbp_mem_dev #(.DATA_W(36)) sbp_mem_dev_i (.CORE_CLK(clk), .NRST(nrst), .PORT(ifa),
        .RD_ACTIVE(ra_act), .WR_ACTIVE(wa_act));
    sbp_mem_dev #(.DATA_W(18)) sbp_mem_dev_b_i (.CORE_CLK(clk), .NRST(nrst), .PORT(ifb),
        .RD_ACTIVE(rb_act), .WR_ACTIVE(wb_act));
    sbp_chk_sva #(.DATA_W(36)) sbp_chk_sva_i (.CORE_CLK(clk), .NRST(nrst),
        .k_phase(ifa.k_phase), .rd_sel_n(ifa.rd_sel_n), .wr_sel_n(ifa.wr_sel_n),
        .lane_write_strobe_n(ifa.lane_write_strobe_n), .q_valid(ifa.q_valid));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Bench plays the controller on the second port
    always @(negedge clk) ifb.k_phase <= nrst ? ~ifb.k_phase : 1'b0;
    always @(posedge clk) if (ok === 1'b1) chk_rsp(qa.size() ? qa.pop_front() : 'x, rq);
    always @(posedge clk) if (ifb.q_valid === 1'b1) chk_beat(qb.size() ? qb.pop_front() : 'x, ifb.q);

    task automatic chk_rsp(input logic [143:0] e, input logic [143:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %0t burst %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_beat(input logic [17:0] e, input logic [17:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %0t beat %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_act(input logic [3:0] e, input logic [3:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %0t activity %b exp %b", $time, g, e);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic req(input bit w, input logic [9:0] a, input logic [143:0] x,
                       input logic [15:0] sn);
        int n;
        @(negedge clk);
        rv <= 1'b1;
        rw <= w;
        ra <= a;
        wd <= x;
        rs <= sn;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 100);
        if (rdy !== 1'b1) begin
            miscompares++;
            close_out();
        end
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 4; j++)
                if (w && !sn[i*4+j]) ma[{a, 2'(i)}][j*9+:9] = x[i*36+j*9+:9];
        if (!w) qa.push_back({ma[{a, 2'h3}], ma[{a, 2'h2}], ma[{a, 2'h1}], ma[{a, 2'h0}]});
        @(negedge clk);
        rv <= 1'b0;
    endtask

    // Command on the next true slot; ig marks a read the device must drop
    task automatic bop(input bit r, input bit w, input bit dup, input bit ig,
                       input logic [9:0] a, input logic [71:0] x, input logic [7:0] sn);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ifb.k_phase !== 1'b0 && n < 4);
        ifb.rd_sel_n <= !r;
        ifb.wr_sel_n <= !w;
        ifb.addr <= a;
        for (int i = 0; i < 4; i++) begin
            if (r && !ig) qb.push_back(mb[{a, 2'(i)}]);
            for (int j = 0; j < 2; j++)
                if (w && !r && !sn[i*2+j]) mb[{a, 2'(i)}][j*9+:9] = x[i*18+j*9+:9];
        end
        for (int s = 1; s <= (w ? 6 : 1); s++) begin
            @(negedge clk);
            ifb.rd_sel_n <= 1'b1;
            ifb.wr_sel_n <= !(dup && s == 2);
            ifb.d <= (s > 1 && s < 6) ? x[((s+2)%4)*18+:18] : ~ifb.d;
            ifb.lane_write_strobe_n <= (s > 1 && s < 6) ? sn[((s+2)%4)*2+:2] : 2'h3;
        end
    endtask

    function automatic logic [71:0] r72();
        return 72'({$urandom, $urandom, $urandom});
    endfunction

    initial begin
        nrst = 0;
        {rv, rw, ra, wd, rs} = '0;
        {ifb.k_phase, ifb.addr, ifb.d} = '0;
        {ifb.rd_sel_n, ifb.wr_sel_n, ifb.lane_write_strobe_n} = '1;
        void'($urandom(42));
        repeat (5) @(negedge clk);
        nrst = 1;
        for (int t = 0; t < 6; t++) begin
            b = t == 0 ? 10'h000 : t == 1 ? 10'h3ff : 10'($urandom);
            req(1, b, {r72(), r72()}, 16'h0000);
            req(1, b, {r72(), r72()}, t == 0 ? 16'hffff : t == 1 ? 16'h7bde : 16'($urandom));
            req(0, b, '0, 16'hffff);
        end
        $display("test burst port done");
        b = 10'($urandom);
        bop(0, 1, 0, 0, b, r72(), 8'h00);
        bop(0, 1, 0, 0, b + 10'h1, r72(), 8'h00);
        bop(0, 1, 0, 0, b, r72(), 8'h9c);
        bop(1, 0, 0, 0, b, '0, 8'hff);
        bop(1, 0, 0, 1, b, '0, 8'hff);
        // Idle true slot: the dropped read still counts as the previous read
        bop(0, 0, 0, 0, b, '0, 8'hff);
        bop(1, 1, 0, 0, b + 10'h1, r72(), 8'h00);
        bop(0, 1, 1, 0, b + 10'h1, r72(), 8'h00);
        bop(1, 0, 0, 0, b + 10'h1, '0, 8'hff);
        bop(0, 1, 0, 0, b, r72(), 8'hff);
        bop(1, 0, 0, 0, b, '0, 8'hff);
        bop(0, 1, 0, 0, b + 10'h1, r72(), 8'h36);
        bop(1, 0, 0, 0, b + 10'h1, '0, 8'hff);
        for (int n = 0; n < 100 && (qa.size() || qb.size()); n++) @(posedge clk);
        if (qa.size() || qb.size()) miscompares++;
        repeat (4) @(negedge clk);
        chk_act(4'h0, {ra_act, wa_act, rb_act, wb_act});
        $display("test direct port done");
        close_out();
    end
endmodule // tb_sram_burst4_byte_write_port
